// file: verilog/ssp_pkg.sv
// Constants, offsets and encodings of the clock-synchronous serial port
package ssp_pkg;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [31:0] REG_MODE_OFS    = 32'hfffff250;
  localparam logic [31:0] REG_DATA_OFS    = 32'hfffff252;
  localparam logic [31:0] REG_CTRL_OFS    = 32'hfffff253;
  localparam logic [31:0] REG_ENABLE_OFS  = 32'hfffff254;
  localparam logic [31:0] REG_GATE_OFS    = 32'hfffff256;
  localparam logic [31:0] REG_IDLE_OFS    = 32'hfffff257;
  localparam int          ADDR_W          = 12;
  localparam int          IDX_W           = 10;

  // operating_mode_select / transfer_status fields
  localparam int          OP_MODE_LSB     = 2;
  localparam int          STAT_XFER_BIT   = 3;
  localparam int          STAT_SHIFT_BIT  = 2;
  localparam logic [1:0]  OP_MODE_PORT    = 2'h0;
  localparam logic [1:0]  OP_MODE_SIO     = 2'h1;
  localparam logic [1:0]  OP_MODE_RST     = OP_MODE_PORT;

  // transfer_control fields
  localparam int          CTRL_START_BIT  = 7;
  localparam int          CTRL_ABORT_BIT  = 6;
  localparam int          CTRL_MODE_LSB   = 4;
  localparam int          CTRL_SEL_LSB    = 0;
  localparam logic [1:0]  XMODE_TX        = 2'h0;
  localparam logic [1:0]  XMODE_TXRX      = 2'h2;
  localparam logic [1:0]  XMODE_RX        = 2'h3;
  localparam logic [1:0]  XMODE_RST       = XMODE_TX;
  localparam logic [2:0]  CLK_SEL_EXT     = 3'h7;
  localparam logic [2:0]  CLK_SEL_RST     = 3'h1;

  // Single-bit control fields
  localparam int          ENABLE_BIT      = 7;
  localparam int          GATE_BIT        = 7;
  localparam int          RUN_IDLE_BIT    = 6;

  // Internal rate: half period is 2^(code+4) system clocks, i.e. fsys/4/2^(code+3)
  localparam logic [3:0]  HALF_EXP_BASE   = 4'h4;
  localparam int          DIV_W           = 10;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  LAST_BIT        = BITS_PER_BYTE - 4'h1;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_WAIT,
    SSP_SHIFT
  } ssp_state_type;

endpackage : ssp_pkg

// file: verilog/ssp_serial_port.sv
// Clock-synchronous 8-bit serial port with APB register access
// Operation
// - Transfer status flag reads 1 during a transfer, 0 once it ends.
// - Shift status flag reads 1 while shifting, 0 when shifting ends.
// - Bit 7 of clock_gate_control turns the internal serial clock off or on.
// - Three-bit clock select: code 111 external clock, other codes internal rates.
// - Internal selection drives one of seven derived rates on the clock pin.
// - Internal serial clock starts every transfer high.
// - Internal clock stops while the data buffer is not serviced.
// - External selection takes the clock from the pin and stops driving it one cycle after it is selected.
// - Transmit shifts on the leading edge, receive on the trailing edge.
// - Leading-edge shifting changes data on the falling clock edge.
// - Trailing-edge shifting takes data on the rising clock edge.
// - Two-bit mode field selects receive, transmit or transmit/receive.
// - Software loads the buffer, sets start; the device then transmits.
// - The byte moves to a shift register and leaves LSB first.
// - Copying the byte to the shift register empties the buffer and pulses interrupt.
// - Internal clock pauses until the next buffer write, then resumes alone.
// - Output keeps the previous last bit until the clock first falls.
// - Clearing start finishes the current byte, then clears the transfer flag.
// - Setting abort stops at once and clears the transfer flag immediately.
`timescale 1ns/10ps

module ssp_serial_port
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ssp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        cpu_idle,
  input  wire logic                        sck_pin,
  output logic                             sck_drive,
  output logic                             sck_oe,
  input  wire logic                        sdi,
  output logic                             sdo,
  output logic                             buffer_empty_irq
);
  import ssp_pkg::*;

  typedef struct packed {
    ssp_state_type    state;
    logic [7:0]       data_buffer;
    logic [7:0]       shreg;
    logic [3:0]       bitcnt;
    logic             tx_full;
    logic             rx_full;
    logic             stop_after;
    logic             enable;
    logic             gate;
    logic             run_in_idle;
    logic [1:0]       op_mode;
    logic             start;
    logic             abort_bit;
    logic [1:0]       xmode;
    logic [2:0]       clk_sel;
    logic [DIV_W-1:0] div;
    logic             sck;
    logic             sck_oe;
    logic             sdo;
    logic             irq;
    logic [2:0]       sck_sync;
    logic [1:0]       sdi_sync;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } ssp_regs_type;

  ssp_regs_type     q;
  ssp_regs_type     d;
  logic             ext_clk;
  logic             run;
  logic             tick;
  logic [DIV_W-1:0] half_mask;
  logic             fall_ev;
  logic             rise_ev;
  logic             ready;
  logic             tx_mode;
  logic             load;
  logic [7:0]       rx_byte;
  logic [IDX_W-1:0] idx;
  logic             hit;
  logic             setup;
  logic             commit;
  logic             wr;
  logic             wr_abort;
  logic             wr_start;
  logic [7:0]       wdat;
  logic [7:0]       rdat;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    d        = q;
    load     = 1'b0;
    fall_ev  = 1'b0;
    rise_ev  = 1'b0;
    wr_abort = 1'b0;
    wr_start = 1'b0;
    rdat     = 8'h00;

    // Bus decode
    idx    = paddr[ADDR_W-1:2];
    wdat   = pwdata[7:0];
    setup  = psel && !penable;
    commit = psel && penable && q.pready;
    wr     = commit && pwrite;
    hit    = idx == REG_MODE_OFS[IDX_W-1:0] || idx == REG_DATA_OFS[IDX_W-1:0] ||
             idx == REG_CTRL_OFS[IDX_W-1:0] || idx == REG_ENABLE_OFS[IDX_W-1:0] ||
             idx == REG_GATE_OFS[IDX_W-1:0] || idx == REG_IDLE_OFS[IDX_W-1:0];

    // Pin synchronisers; only stages 1 and 2 feed logic
    d.sck_sync = {q.sck_sync[1:0], sck_pin};
    d.sdi_sync = {q.sdi_sync[0], sdi};

    ext_clk = q.clk_sel == CLK_SEL_EXT;
    tx_mode = q.xmode != XMODE_RX;
    rx_byte = {q.sdi_sync[1], q.shreg[7:1]};
    unique case (q.xmode)
      XMODE_RX:   ready = !q.rx_full;
      XMODE_TXRX: ready = q.tx_full && !q.rx_full;
      default:    ready = q.tx_full;
    endcase

    // Internal rate divider; stopped by the gate, the enable, or idle
    run       = q.enable && q.gate && q.op_mode == OP_MODE_SIO &&
                !(cpu_idle && !q.run_in_idle);
    half_mask = ~({DIV_W{1'b1}} << (q.clk_sel + HALF_EXP_BASE));
    tick      = run && !ext_clk && (q.div & half_mask) == half_mask;
    if (run) begin
      d.div = q.div + 1'b1;
    end

    // Pin is driven only for an internal clock
    d.sck_oe = !ext_clk && q.enable && q.op_mode == OP_MODE_SIO;

    if (q.state == SSP_SHIFT) begin
      if (ext_clk) begin
        fall_ev = !q.sck_sync[1] && q.sck_sync[2];
        rise_ev = q.sck_sync[1] && !q.sck_sync[2];
      end else if (tick) begin
        d.sck   = ~q.sck;
        fall_ev = q.sck;
        rise_ev = !q.sck;
      end
    end

    // Data out only on falling edges, so the old last bit holds until then
    if (fall_ev) begin
      d.sdo = q.shreg[0];
    end

    // APB read side effect: reading the buffer frees it for reception
    if (commit && !pwrite && idx == REG_DATA_OFS[IDX_W-1:0]) begin
      d.rx_full = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    unique case (q.state)
      SSP_IDLE: begin
        d.sck = 1'b1;
      end
      SSP_WAIT: begin
        if (!q.start) begin
          d.state = SSP_IDLE;
        end else if (ready) begin
          load    = tx_mode;
          d.state = SSP_SHIFT;
        end
      end
      SSP_SHIFT: begin
        if (rise_ev) begin
          d.shreg  = rx_byte;
          d.bitcnt = q.bitcnt + 4'h1;
          if (q.bitcnt == LAST_BIT) begin
            d.bitcnt = 4'h0;
            if (q.xmode != XMODE_TX) begin
              d.data_buffer = rx_byte;
              d.rx_full     = 1'b1;
            end
            if (!q.start || q.stop_after) begin
              d.state      = SSP_IDLE;
              d.stop_after = 1'b0;
            end else if (!ext_clk) begin
              d.state = SSP_WAIT;
            end else if (ready) begin
              load = tx_mode;
            end else if (tx_mode) begin
              d.shreg      = q.data_buffer;
              d.stop_after = 1'b1;
            end
          end
        end
      end
      default: begin
        d.state = SSP_IDLE;
      end
    endcase

    // Copy to the shift register empties the buffer
    if (load) begin
      d.shreg   = q.data_buffer;
      d.tx_full = 1'b0;
    end
    d.irq = load;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; bus writes come last so a buffer fill beats a load

    if (wr && idx == REG_ENABLE_OFS[IDX_W-1:0]) begin
      d.enable = wdat[ENABLE_BIT];
    end
    if (wr && q.enable) begin
      unique case (idx)
        REG_MODE_OFS[IDX_W-1:0]: begin
          d.op_mode = wdat[OP_MODE_LSB +: 2];
        end
        REG_DATA_OFS[IDX_W-1:0]: begin
          d.data_buffer = wdat;
          d.tx_full     = 1'b1;
        end
        REG_CTRL_OFS[IDX_W-1:0]: begin
          d.start     = wdat[CTRL_START_BIT];
          d.abort_bit = wdat[CTRL_ABORT_BIT];
          d.xmode     = wdat[CTRL_MODE_LSB +: 2];
          d.clk_sel   = wdat[CTRL_SEL_LSB +: 3];
          wr_abort    = wdat[CTRL_ABORT_BIT];
          wr_start    = wdat[CTRL_START_BIT] && !wdat[CTRL_ABORT_BIT];
        end
        REG_GATE_OFS[IDX_W-1:0]: begin
          d.gate = wdat[GATE_BIT];
        end
        REG_IDLE_OFS[IDX_W-1:0]: begin
          d.run_in_idle = wdat[RUN_IDLE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Abort parks the clock high so the next frame starts from idle
    if (wr_abort) begin
      d.state      = SSP_IDLE;
      d.bitcnt     = 4'h0;
      d.stop_after = 1'b0;
      d.sck        = 1'b1;
    end else if (wr_start && q.state == SSP_IDLE && q.op_mode == OP_MODE_SIO) begin
      d.state  = SSP_WAIT;
      d.bitcnt = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read data, registered in the setup cycle: no wait states

    unique case (idx)
      REG_MODE_OFS[IDX_W-1:0]: begin
        rdat[STAT_XFER_BIT]  = q.state != SSP_IDLE;
        rdat[STAT_SHIFT_BIT] = q.state == SSP_SHIFT;
      end
      REG_DATA_OFS[IDX_W-1:0]: rdat = q.data_buffer;
      REG_CTRL_OFS[IDX_W-1:0]: begin
        rdat[CTRL_START_BIT]          = q.start;
        rdat[CTRL_ABORT_BIT]          = q.abort_bit;
        rdat[CTRL_MODE_LSB +: 2]      = q.xmode;
        rdat[CTRL_SEL_LSB +: 3]       = q.clk_sel;
      end
      REG_ENABLE_OFS[IDX_W-1:0]: rdat[ENABLE_BIT] = q.enable;
      REG_GATE_OFS[IDX_W-1:0]:   rdat[GATE_BIT] = q.gate;
      REG_IDLE_OFS[IDX_W-1:0]:   rdat[RUN_IDLE_BIT] = q.run_in_idle;
      default: begin
      end
    endcase
    // While disabled only the enable register answers with content
    if (!q.enable && idx != REG_ENABLE_OFS[IDX_W-1:0]) begin
      rdat = 8'h00;
    end

    d.pready = setup;
    if (setup) begin
      d.prdata  = {24'h000000, rdat};
      d.pslverr = !hit;
    end else begin
      d.pslverr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q             <= '0;
      q.state       <= SSP_IDLE;
      q.op_mode     <= OP_MODE_RST;
      q.xmode       <= XMODE_RST;
      q.clk_sel     <= CLK_SEL_RST;
      q.sck         <= 1'b1;
      q.sdo         <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign sck_drive        = q.sck;
  assign sck_oe           = q.sck_oe;
  assign sdo              = q.sdo;
  assign buffer_empty_irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  abort_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_abort |=> q.state == SSP_IDLE && q.bitcnt == 4'h0)
    else $error("abort did not stop the transfer");

  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && idx == REG_MODE_OFS[IDX_W-1:0] && q.enable
    |=> prdata[STAT_XFER_BIT] == ($past(q.state) != SSP_IDLE))
    else $error("transfer flag read wrong");

  shift_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && idx == REG_MODE_OFS[IDX_W-1:0] && q.enable
    |=> prdata[STAT_SHIFT_BIT] == ($past(q.state) == SSP_SHIFT))
    else $error("shift flag read wrong");

  gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.gate && !ext_clk |=> $stable(sck_drive))
    else $error("serial clock moved while gated off");

  ext_no_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_clk && $past(ext_clk) |-> !sck_oe)
    else $error("clock pin driven with external clock");

  start_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.state == SSP_WAIT && !ext_clk |-> sck_drive)
    else $error("internal clock not high while waiting");

  data_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(sdo) |-> $past(fall_ev))
    else $error("output bit changed off a falling edge");

  empty_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> buffer_empty_irq ##1 !buffer_empty_irq)
    else $error("buffer empty pulse missing");

  stop_finish_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.state == SSP_SHIFT && !q.start && !wr_start |=> q.state != SSP_WAIT)
    else $error("cleared start did not end after the byte");

  bit_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_ev && q.bitcnt == LAST_BIT |=> q.bitcnt == 4'h0)
    else $error("byte not closed after eight bits");

endmodule : ssp_serial_port

// file: bench/ssp_peer.sv
// Behavioural serial peer on the far side of the clock and data pins
`timescale 1ns/10ps

module ssp_peer (
  input  wire logic       sck_line,
  input  wire logic       sdo,
  output logic            sck_ext,
  output logic            sdi,
  output logic [7:0]      rx_byte,
  output logic [7:0]      rx_count,
  output logic [7:0]      tx_log
);
  logic [7:0] tx_pat;

  initial begin
    sck_ext  = 1'b1;
    sdi      = 1'b0;
    rx_byte  = 8'h00;
    rx_count = 8'h00;
    tx_log   = 8'h00;
    tx_pat   = 8'h96;
  end

  // Data out is taken on the rising edge, LSB first
  always @(posedge sck_line) begin
    rx_byte  <= {sdo, rx_byte[7:1]};
    rx_count <= rx_count + 8'h01;
  end

  // New bit on each falling edge; the pattern rotates, repeating every eight bits, and tx_log records each bit sent
  always @(negedge sck_line) begin
    sdi    <= tx_pat[0];
    tx_log <= {tx_pat[0], tx_log[7:1]};
    tx_pat <= {tx_pat[0], tx_pat[7:1]};
  end

  // Eight pulses of 48 ns; the clock stands high between frames, phase unrelated to pclk
  task automatic clock_byte();
    #7;
    for (int i = 0; i < 8; i++) begin
      #24 sck_ext = 1'b0;
      #24 sck_ext = 1'b1;
    end
  endtask : clock_byte
endmodule : ssp_peer

// file: bench/tb_top.sv
// Self-checking bench for the clock-synchronous serial port
`timescale 1ns/10ps

module tb_top;
  import ssp_pkg::*;
  localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'(REG_MODE_OFS << 2);
  localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'(REG_DATA_OFS << 2);
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(REG_CTRL_OFS << 2);
  localparam logic [ADDR_W-1:0] A_EN   = ADDR_W'(REG_ENABLE_OFS << 2);
  localparam logic [ADDR_W-1:0] A_GATE = ADDR_W'(REG_GATE_OFS << 2);
  localparam logic [ADDR_W-1:0] A_IDLE = ADDR_W'(REG_IDLE_OFS << 2);
  localparam logic [ADDR_W-1:0] A_BAD  = ADDR_W'(32'hfffff251 << 2);

  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              cpu_idle, sck_o, sck_oe, sdi, sdo, irq, sck_ext, sck_line;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [7:0]        rx_byte, rx_count, tx_log, base;
  int                miscompares, checks, irqs, b_irq;

  always #2.5 pclk = ~pclk;
  // Clock pin: the device when it drives, else the peer, whose clock stands high between frames
  assign sck_line = sck_oe ? sck_o : sck_ext;
  always @(posedge pclk) if (irq === 1'b1) irqs <= irqs + 1;

  ssp_serial_port DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .sck_pin(sck_line), .sck_drive(sck_o), .sck_oe(sck_oe), .sdi(sdi),
    .sdo(sdo), .buffer_empty_irq(irq)
  );
  ssp_peer peer (
    .sck_line(sck_line), .sdo(sdo), .sck_ext(sck_ext), .sdi(sdi),
    .rx_byte(rx_byte), .rx_count(rx_count), .tx_log(tx_log)
  );

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Entered just after a rising edge; holds the request until pready is sampled high
  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 32'h0, 32'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rdchk(string name, logic [ADDR_W-1:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  task automatic wait_bits(logic [7:0] n);
    for (int i = 0; i < 4000 && rx_count !== n; i++) @(posedge pclk);
    check("bit count", rx_count, n);
  endtask : wait_bits

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(A_GATE, 8'h80);
    wr(A_EN, 8'h80);
    rdchk("gate after disabled write", A_GATE, 32'h0);
    rdchk("enable", A_EN, 32'h80);
    wr(A_MODE, 8'h04);
    rdchk("status idle", A_MODE, 32'h0);
    apb(1'b0, A_BAD, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    wr(A_GATE, 8'h80);
    rdchk("gate", A_GATE, 32'h80);
    wr(A_IDLE, 8'h40);
    rdchk("run in idle", A_IDLE, 32'h40);
  endtask : t_regs

  task automatic t_internal();
    base  = rx_count;
    b_irq = irqs;
    wr(A_CTRL, 8'h40);
    wr(A_DATA, 8'ha5);
    wr(A_CTRL, 8'h80);
    check("clock starts high", {29'h0, sck_oe, sck_o, sdo}, 32'h7);
    wait_bits(base + 8'h08);
    check("first byte", rx_byte, 8'ha5);
    repeat (64) @(posedge pclk);
    check("clock held", {rx_count, 7'h0, sck_o}, {base + 8'h08, 8'h01});
    rdchk("waiting status", A_MODE, 32'h08);
    check("empty pulses", irqs - b_irq, 1);
    cpu_idle <= 1'b1;
    wr(A_DATA, 8'h3c);
    wr(A_CTRL, 8'h00);
    wait_bits(base + 8'h10);
    check("second byte", rx_byte, 8'h3c);
    repeat (8) @(posedge pclk);
    rdchk("ended status", A_MODE, 32'h0);
    cpu_idle <= 1'b0;
  endtask : t_internal

  task automatic t_abort();
    int n;
    base = rx_count;
    wr(A_CTRL, 8'h41);
    wr(A_DATA, 8'h5a);
    wr(A_CTRL, 8'h81);
    check("kept last bit", {31'h0, sdo}, 32'h0);
    while (sck_o !== 1'b0) @(posedge pclk);
    for (n = 0; sck_o === 1'b0 && n < 200; n++) @(posedge pclk);
    check("half period", n, 1 << (HALF_EXP_BASE + 1));
    wait_bits(base + 8'h03);
    wr(A_CTRL, 8'h40);
    rdchk("aborted status", A_MODE, 32'h0);
    repeat (100) @(posedge pclk);
    check("no shifting after abort", rx_count, base + 8'h03);
  endtask : t_abort

  task automatic t_external();
    base  = rx_count;
    b_irq = irqs;
    wr(A_CTRL, 8'h47);
    @(posedge pclk);
    check("pin released", {31'h0, sck_oe}, 32'h0);
    wr(A_DATA, 8'hc3);
    wr(A_CTRL, 8'h87);
    apb(1'b0, A_MODE, 32'h0);
    check("active", {31'h0, rd[STAT_XFER_BIT]}, 32'h1);
    wr(A_CTRL, 8'h07);
    peer.clock_byte();
    wait_bits(base + 8'h08);
    check("external byte", rx_byte, 8'hc3);
    check("empty pulse", irqs - b_irq, 1);
    repeat (20) @(posedge pclk);
    rdchk("external end", A_MODE, 32'h0);
  endtask : t_external

  task automatic t_modes();
    logic [1:0] m;
    for (int k = 0; k < 2; k++) begin
      m    = k ? XMODE_RX : XMODE_TXRX;
      base = rx_count;
      wr(A_CTRL, {2'b01, m, 4'h0});
      wr(A_DATA, 8'h11);
      wr(A_CTRL, {2'b10, m, 4'h0});
      wr(A_CTRL, {2'b00, m, 4'h0});
      wait_bits(base + 8'h08);
      repeat (8) @(posedge pclk);
      rdchk("received byte", A_DATA, {24'h0, tx_log});
      if (k == 0) check("sent byte", rx_byte, 8'h11);
      rdchk("mode end", A_MODE, 32'h0);
    end
  endtask : t_modes

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = '0;
    pwdata   = 32'h0;
    cpu_idle = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_internal();
    t_abort();
    t_external();
    t_modes();
    summarize();
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule : tb_top
